// ===== rsw_top.sv
// Purpose: Reset source capture, reset hold and watchdog reset for the CPU core
// Assumes: Reset pin and power-on detect arrive asynchronously
// Notes:   resetn_i is the system reset; por_i marks a power-on event
// Function
// - Watchdog counter runs freely, interval selectable, software clear restarts it
// - Time-out sets the time-out interrupt flag, control bit 3
// - Enabled and uncleared, a watchdog reset follows 512 clocks after the flag
// - Watchdog reset is held two machine cycles, then fetch starts at zero
// - Program counter is forced to zero while any reset is applied
// - Reset leaves the on-chip data RAM untouched
// - Every reset loads the stack pointer with 07h
// - Reset clears registers, interrupt enables and timers disabled
// - Reset loads port latches with FFh
// - Power-on flag, control bit 6, set by power-on reset, by system reset or by a software write
// - Watchdog reset flag, bit 2, set by watchdog reset, cleared by power-on
// - Power-on and system reset clear watchdog reset enable, bit 1; pin and watchdog resets keep it
// - Time-out flag requests interrupt only when extra enable bit 4 is set
// - Time-out flag is writable by software to raise an interrupt; event status bits only clear
// - Reset pin sampled at the fourth clock phase; driver holds two machine cycles
// - A machine cycle is four clocks, eight clocks minimum pin width
// - Reset stays while pin high and for two machine cycles after the first low sample
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "rsw_cfg.svh"
module rsw_top #(
   parameter int RAM_DEPTH = 16,
   parameter int DOG_CNT_W = 26
) (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        rst_pin_i,
   input  wire logic        por_i,
   input  wire logic        pc_step_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   output logic             cpu_rst_o,
   output logic      [15:0] pc_o,
   output logic      [7:0]  sp_o,
   output logic      [7:0]  port0_o,
   output logic      [7:0]  port1_o,
   output logic      [7:0]  port2_o,
   output logic      [7:0]  port3_o,
   output logic             dog_irq_o,
   output logic             irq_o
);
   localparam int HOLD_CLKS = `RSW_RST_HOLD_MC * `RSW_CLK_PER_MC;

   // Synchronisers for pin and power-on detect
   logic [1:0] pin_sync_reg;
   logic [1:0] por_sync_reg;
   logic       pin_s;
   logic       por_s;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pin_sync_reg <= 2'b00;
         por_sync_reg <= 2'b00;
      end else begin
         pin_sync_reg <= {pin_sync_reg[0], rst_pin_i};
         por_sync_reg <= {por_sync_reg[0], por_i};
      end
   end
   assign pin_s = pin_sync_reg[1];
   assign por_s = por_sync_reg[1];

   // Machine-cycle phase counter
   logic [1:0] phase_reg;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         phase_reg <= 2'b00;
      end else begin
         phase_reg <= phase_reg + 2'b01;
      end
   end

   // Pin sampled at fourth phase; two consecutive high samples start reset, one high sample keeps it
   logic [1:0] pin_samp_reg;
   logic       ext_req;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pin_samp_reg <= 2'b00;
      end else if (phase_reg == `RSW_PHASE_SAMPLE) begin
         pin_samp_reg <= {pin_samp_reg[0], pin_s};
      end
   end
   assign ext_req = pin_samp_reg[0] && (pin_samp_reg[1] || cpu_rst_o);

   // Power-on edge
   logic por_prev_reg;
   logic por_evt;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         por_prev_reg <= 1'b0;
      end else begin
         por_prev_reg <= por_s;
      end
   end
   assign por_evt = por_s && !por_prev_reg;

   // Control register fields
   logic       por_flag_reg;
   logic       tof_reg;
   logic       drf_reg;
   logic       dre_reg;
   logic [1:0] isel_reg;
   logic [4:0] xie_reg;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_mask_reg;

   logic wr_ctl;
   logic wr_xie;
   logic dog_clear;
   assign wr_ctl    = wr_i && (addr_i == `RSW_ADDR_WDCTL);
   assign wr_xie    = wr_i && (addr_i == `RSW_ADDR_XIE);
   // Writing bit 0 of the control register restarts the watchdog
   assign dog_clear = wr_ctl && wdata_i[0];

   // Reset sequencer
   rsw_pkg::rsw_state_type state_reg;
   logic [3:0]             hold_cnt_reg;
   logic [9:0]             dog_wait_reg;
   logic                   dog_armed_reg;
   logic                   dog_fire;
   logic                   tick;
   rsw_pkg::rsw_src_type   src;

   rsw_dog_timer #(
      .CNT_W (DOG_CNT_W)
   ) u_dog (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .hold_i   (cpu_rst_o),
      .clear_i  (dog_clear),
      .sel_i    (isel_reg),
      .tick_o   (tick)
   );

   // 512-clock grace count after the time-out flag
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         dog_armed_reg <= 1'b0;
         dog_wait_reg  <= '0;
      end else if (dog_clear || cpu_rst_o) begin
         dog_armed_reg <= 1'b0;
         dog_wait_reg  <= '0;
      end else if (tick && !dog_armed_reg) begin
         dog_armed_reg <= 1'b1;
         dog_wait_reg  <= '0;
      end else if (dog_armed_reg) begin
         dog_wait_reg <= dog_wait_reg + 10'd1;
      end
   end
   assign dog_fire = dog_armed_reg && dre_reg && (dog_wait_reg == 10'(`RSW_DOG_DELAY - 1));

   assign src.por = por_evt;
   assign src.ext = ext_req;
   assign src.dog = dog_fire;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_reg    <= rsw_pkg::RSW_HOLD;
         hold_cnt_reg <= '0;
      end else begin
         unique case (state_reg)
            rsw_pkg::RSW_RUN: begin
               if (src.por || src.ext || src.dog) begin
                  state_reg    <= rsw_pkg::RSW_HOLD;
                  hold_cnt_reg <= '0;
               end
            end
            rsw_pkg::RSW_HOLD: begin
               if (src.por || src.ext) begin
                  hold_cnt_reg <= '0;
               end else if (hold_cnt_reg == 4'(HOLD_CLKS - 1)) begin
                  state_reg <= rsw_pkg::RSW_RUN;
               end else begin
                  hold_cnt_reg <= hold_cnt_reg + 4'd1;
               end
            end
            default: begin
               state_reg <= rsw_pkg::RSW_RUN;
            end
         endcase
      end
   end

   logic cpu_rst_next;
   assign cpu_rst_next = (state_reg != rsw_pkg::RSW_RUN) || src.por || src.ext || src.dog;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cpu_rst_o <= 1'b1;
      end else begin
         cpu_rst_o <= cpu_rst_next;
      end
   end

   // Program counter: cleared on the next reset level, so it is zero in every reset cycle
   always_ff @(posedge clk_i) begin
      if (!resetn_i || cpu_rst_next) begin
         pc_o <= `RSW_PC_RESET;
      end else if (pc_step_i) begin
         pc_o <= pc_o + 16'h0001;
      end
   end

   // CPU state registers with reset values
   rsw_pkg::rsw_cpu_type cpu_reg;

   always_ff @(posedge clk_i) begin
      if (!resetn_i || cpu_rst_o) begin
         cpu_reg.sp <= `RSW_SP_RESET;
         cpu_reg.p0 <= `RSW_PORT_RESET;
         cpu_reg.p1 <= `RSW_PORT_RESET;
         cpu_reg.p2 <= `RSW_PORT_RESET;
         cpu_reg.p3 <= `RSW_PORT_RESET;
      end else if (wr_i) begin
         unique case (addr_i)
            `RSW_ADDR_SP:    cpu_reg.sp <= wdata_i;
            `RSW_ADDR_PORT0: cpu_reg.p0 <= wdata_i;
            `RSW_ADDR_PORT1: cpu_reg.p1 <= wdata_i;
            `RSW_ADDR_PORT2: cpu_reg.p2 <= wdata_i;
            `RSW_ADDR_PORT3: cpu_reg.p3 <= wdata_i;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      sp_o    <= cpu_reg.sp;
      port0_o <= cpu_reg.p0;
      port1_o <= cpu_reg.p1;
      port2_o <= cpu_reg.p2;
      port3_o <= cpu_reg.p3;
   end

   // Interrupt enable and interval select cleared by every reset
   always_ff @(posedge clk_i) begin
      if (!resetn_i || cpu_rst_o) begin
         xie_reg  <= 5'h00;
         isel_reg <= 2'b00;
      end else begin
         if (wr_xie) begin
            xie_reg <= wdata_i[4:0];
         end
         if (addr_i == `RSW_ADDR_INTSEL && wr_i) begin
            isel_reg <= wdata_i[1:0];
         end
      end
   end

   // Source flags: power-on has priority over a simultaneous watchdog reset
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         por_flag_reg <= 1'b1;
         drf_reg      <= 1'b0;
         dre_reg      <= 1'b0;
      end else if (src.por) begin
         por_flag_reg <= 1'b1;
         drf_reg      <= 1'b0;
         dre_reg      <= 1'b0;
      end else if (src.dog) begin
         drf_reg <= 1'b1;
      end else if (wr_ctl) begin
         por_flag_reg <= wdata_i[`RSW_BIT_POR];
         drf_reg      <= wdata_i[`RSW_BIT_DRF];
         dre_reg      <= wdata_i[`RSW_BIT_DRE];
      end
   end

   // Time-out flag: hardware set wins over software write
   always_ff @(posedge clk_i) begin
      if (!resetn_i || cpu_rst_o) begin
         tof_reg <= 1'b0;
      end else if (tick) begin
         tof_reg <= 1'b1;
      end else if (wr_ctl) begin
         tof_reg <= wdata_i[`RSW_BIT_TOF];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         dog_irq_o <= 1'b0;
      end else begin
         dog_irq_o <= tof_reg && xie_reg[`RSW_BIT_XIE_WD];
      end
   end

   // Sticky event status, write one to clear
   logic [1:0] evt;
   assign evt = {src.dog, tick};
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         irq_stat_reg <= 2'b00;
         irq_mask_reg <= 2'b00;
      end else begin
         if (wr_i && addr_i == `RSW_ADDR_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~wdata_i[1:0]) | evt;
         end else begin
            irq_stat_reg <= irq_stat_reg | evt;
         end
         if (wr_i && addr_i == `RSW_ADDR_IRQ_MASK) begin
            irq_mask_reg <= wdata_i[1:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // Data RAM: no reset term, contents survive every reset
   logic [7:0] ram_mem [RAM_DEPTH];
   logic [$clog2(RAM_DEPTH)-1:0] ram_ptr_reg;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ram_ptr_reg <= '0;
      end else if (wr_i && addr_i == `RSW_ADDR_RAM_ADDR) begin
         ram_ptr_reg <= wdata_i[$clog2(RAM_DEPTH)-1:0];
      end
   end
   always_ff @(posedge clk_i) begin
      if (wr_i && addr_i == `RSW_ADDR_RAM_DATA) begin
         ram_mem[ram_ptr_reg] <= wdata_i;
      end
   end

   // Read port, data one cycle after strobe
   logic [7:0] rd_mux;
   always_comb begin
      unique case (addr_i)
         `RSW_ADDR_WDCTL:    rd_mux = {1'b0, por_flag_reg, 1'b0, 1'b0, tof_reg, drf_reg, dre_reg, 1'b0};
         `RSW_ADDR_XIE:      rd_mux = {3'b000, xie_reg};
         `RSW_ADDR_SP:       rd_mux = cpu_reg.sp;
         `RSW_ADDR_PORT0:    rd_mux = cpu_reg.p0;
         `RSW_ADDR_PORT1:    rd_mux = cpu_reg.p1;
         `RSW_ADDR_PORT2:    rd_mux = cpu_reg.p2;
         `RSW_ADDR_PORT3:    rd_mux = cpu_reg.p3;
         `RSW_ADDR_PC_LO:    rd_mux = pc_o[7:0];
         `RSW_ADDR_PC_HI:    rd_mux = pc_o[15:8];
         `RSW_ADDR_IRQ_STAT: rd_mux = {6'h00, irq_stat_reg};
         `RSW_ADDR_IRQ_MASK: rd_mux = {6'h00, irq_mask_reg};
         `RSW_ADDR_INTSEL:   rd_mux = {6'h00, isel_reg};
         `RSW_ADDR_RAM_ADDR: rd_mux = 8'(ram_ptr_reg);
         `RSW_ADDR_RAM_DATA: rd_mux = ram_mem[ram_ptr_reg];
         default:            rd_mux = `RSW_ZERO8;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rdata_o <= `RSW_ZERO8;
      end else if (rd_i) begin
         rdata_o <= rd_mux;
      end else begin
         rdata_o <= `RSW_ZERO8;
      end
   end
endmodule

// ===== rsw_cfg.svh
// Purpose: Constants for the reset source and watchdog reset block
// Assumes: 100 MHz clock, machine cycle of four clocks
// Notes:   Register addresses are local to this block's plain register port
`ifndef RSW_CFG_SVH
`define RSW_CFG_SVH

`define RSW_ADDR_WDCTL     4'h0
`define RSW_ADDR_XIE       4'h1
`define RSW_ADDR_SP        4'h2
`define RSW_ADDR_PORT0     4'h3
`define RSW_ADDR_PORT1     4'h4
`define RSW_ADDR_PORT2     4'h5
`define RSW_ADDR_PORT3     4'h6
`define RSW_ADDR_PC_LO     4'h7
`define RSW_ADDR_PC_HI     4'h8
`define RSW_ADDR_IRQ_STAT  4'h9
`define RSW_ADDR_IRQ_MASK  4'hA
`define RSW_ADDR_INTSEL    4'hB
`define RSW_ADDR_RAM_ADDR  4'hC
`define RSW_ADDR_RAM_DATA  4'hD

`define RSW_BIT_POR        6
`define RSW_BIT_TOF        3
`define RSW_BIT_DRF        2
`define RSW_BIT_DRE        1
`define RSW_BIT_XIE_WD     4

`define RSW_SP_RESET       8'h07
`define RSW_PORT_RESET     8'hFF
`define RSW_PC_RESET       16'h0000
`define RSW_ZERO8          8'h00

`define RSW_CLK_PER_MC     4
`define RSW_PHASE_SAMPLE   2'h3
`define RSW_DOG_DELAY      512
`define RSW_RST_HOLD_MC    2
`define RSW_IRQ_TIMEOUT    0
`define RSW_IRQ_DOGRST     1

`endif

// ===== rsw_pkg.sv
// Purpose: Types for the reset source and watchdog reset block
// Assumes: Nothing beyond the constants header
// Notes:   Types only
package rsw_pkg;
   typedef enum logic [1:0] {
      RSW_RUN   = 2'b00,
      RSW_HOLD  = 2'b01,
      RSW_TRAIL = 2'b10
   } rsw_state_type;

   typedef struct packed {
      logic por;
      logic ext;
      logic dog;
   } rsw_src_type;

   typedef struct packed {
      logic [7:0] sp;
      logic [7:0] p0;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [7:0] p3;
   } rsw_cpu_type;
endpackage

// ===== rsw_dog_timer.sv
// Purpose: Free running watchdog counter with selectable time-out
// Assumes: Clear pulse and interval select from the same clock domain
// Notes:   Time-out pulse occurs once per interval
`timescale 1ns/1ps
module rsw_dog_timer #(
   parameter int CNT_W = 26
) (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       hold_i,
   input  wire logic       clear_i,
   input  wire logic [1:0] sel_i,
   output logic            tick_o
);
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic [CNT_W-1:0] limit;

   always_comb begin
      unique case (sel_i)
         2'b00: limit = CNT_W'(17'h1_FFFF);
         2'b01: limit = CNT_W'(20'hF_FFFF);
         2'b10: limit = CNT_W'(23'h7F_FFFF);
         2'b11: limit = {CNT_W{1'b1}};
      endcase
   end

   always_comb begin
      count_next = count_reg + CNT_W'(1);
      if (clear_i || hold_i || count_reg >= limit) begin
         count_next = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         count_reg <= '0;
         tick_o    <= 1'b0;
      end else begin
         count_reg <= count_next;
         tick_o    <= !clear_i && !hold_i && (count_reg >= limit);
      end
   end
endmodule

// ===== rsw_top_props.sv
// Purpose: Port-level assertions for the reset source and watchdog reset block
// Assumes: One clock, synchronous active-low system reset
// Notes:   Bound to every instance of rsw_top
`timescale 1ns/1ps
module rsw_top_props (
   input wire logic        clk_i,
   input wire logic        resetn_i,
   input wire logic        rst_pin_i,
   input wire logic        pc_step_i,
   input wire logic        rd_i,
   input wire logic [7:0]  rdata_o,
   input wire logic        cpu_rst_o,
   input wire logic [15:0] pc_o,
   input wire logic [7:0]  sp_o,
   input wire logic [7:0]  port0_o,
   input wire logic [7:0]  port1_o,
   input wire logic [7:0]  port2_o,
   input wire logic [7:0]  port3_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   a_pc_zero: assert property (cpu_rst_o |-> pc_o == 16'h0000)
      else $error("pc not zero in reset");
   a_pc_count: assert property (!cpu_rst_o && $past(!cpu_rst_o) |->
      pc_o == $past(pc_o) + 16'($past(pc_step_i)))
      else $error("pc did not follow step");
   a_sp_load: assert property ($fell(cpu_rst_o) |-> sp_o == 8'h07)
      else $error("stack pointer not 07 after reset");
   a_port_load: assert property ($fell(cpu_rst_o) |->
      {port0_o, port1_o, port2_o, port3_o} == 32'hFFFF_FFFF)
      else $error("port latches not FF after reset");
   a_rst_hold: assert property ($rose(cpu_rst_o) |-> cpu_rst_o [*8])
      else $error("reset shorter than two machine cycles");
   a_pin_reset: assert property (rst_pin_i [*8] ##1 rst_pin_i [*8] |-> cpu_rst_o)
      else $error("held pin did not keep reset");
   a_rst_trail: assert property ($fell(cpu_rst_o) |-> !$past(rst_pin_i, 3))
      else $error("reset released with pin high");
   a_read_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside read cycle");
endmodule

bind rsw_top rsw_top_props u_props (.clk_i(clk_i), .resetn_i(resetn_i), .rst_pin_i(rst_pin_i),
   .pc_step_i(pc_step_i), .rd_i(rd_i), .rdata_o(rdata_o), .cpu_rst_o(cpu_rst_o), .pc_o(pc_o),
   .sp_o(sp_o), .port0_o(port0_o), .port1_o(port1_o), .port2_o(port2_o), .port3_o(port3_o));

// ===== rsw_src_model.sv
// Purpose: Reset pin driver and power-on detector beside the block
// Assumes: Tasks are entered just after a rising clock edge
// Notes:   Pin is pulled low when released
`timescale 1ns/1ps
module rsw_src_model (
   input  wire logic clk_i,
   output logic      rst_pin_o,
   output logic      por_o
);
   initial begin
      rst_pin_o = 1'h0;
      por_o     = 1'h0;
   end
   task pin_pulse(input int len);
      rst_pin_o <= 1'h1;
      repeat (len) @(posedge clk_i);
      rst_pin_o <= 1'h0;
   endtask
   task por_pulse(input int len);
      por_o <= 1'h1;
      repeat (len) @(posedge clk_i);
      por_o <= 1'h0;
   endtask
endmodule

// ===== testbench.sv
// Purpose: Self-checking bench for the reset source and watchdog reset block
// Assumes: Watchdog interval 3 shortened to 1024 clocks
// Notes:   One-cycle strobes, read data in the following cycle
`timescale 1ns/1ps
`include "rsw_cfg.svh"
module testbench;
   logic        clk_i     = 1'h0;
   logic        resetn_i  = 1'h0;
   logic        pc_step_i = 1'h0;
   logic [3:0]  addr_i    = 4'h0;
   logic [7:0]  wdata_i   = 8'h00;
   logic        wr_i      = 1'h0;
   logic        rd_i      = 1'h0;
   logic [7:0]  rdata_o, sp_o, port0_o, port1_o, port2_o, port3_o, rv;
   logic [15:0] pc_o;
   logic        cpu_rst_o, dog_irq_o, irq_o, rst_pin, por;
   int          err_count = 0;
   int          cmp_count = 0;
   int          n;

   rsw_src_model src (.clk_i(clk_i), .rst_pin_o(rst_pin), .por_o(por));
   rsw_top #(.DOG_CNT_W(10)) dut (.clk_i(clk_i), .resetn_i(resetn_i), .rst_pin_i(rst_pin),
      .por_i(por), .pc_step_i(pc_step_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .cpu_rst_o(cpu_rst_o), .pc_o(pc_o), .sp_o(sp_o),
      .port0_o(port0_o), .port1_o(port1_o), .port2_o(port2_o), .port3_o(port3_o),
      .dog_irq_o(dog_irq_o), .irq_o(irq_o));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   task report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      wr_i    <= 1'h1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task rd(input logic [3:0] a, output logic [7:0] d);
      rd_i   <= 1'h1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'h0;
      #1 d = rdata_o;
      @(posedge clk_i);
   endtask
   task rdc(input logic [3:0] a, input logic [7:0] e);
      rd(a, rv);
      chk({8'h00, rv}, {8'h00, e});
   endtask
   task chk_irq(input logic [1:0] e);
      #1 chk({14'h0000, dog_irq_o, irq_o}, {14'h0000, e});
      @(posedge clk_i);
   endtask
   task wait_for(input logic dog, input logic lvl, input int lim);
      n = 0;
      #1;
      while (((dog ? dog_irq_o : cpu_rst_o) !== lvl) && n < lim) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n >= lim) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, ~lvl, lvl);
         report_and_stop();
      end
      @(posedge clk_i);
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      resetn_i <= 1'h1;
      wait_for(1'h0, 1'h0, 40);
      rdc(`RSW_ADDR_WDCTL, 8'h40);
      chk({8'h00, sp_o}, 16'h0007);
      chk({port0_o, port3_o}, 16'hFFFF);
      chk({port1_o, port2_o}, 16'hFFFF);
      $display("Test power-up done");
      wr(`RSW_ADDR_WDCTL, 8'h02);
      wr(`RSW_ADDR_RAM_ADDR, 8'h03);
      wr(`RSW_ADDR_RAM_DATA, 8'hA5);
      pc_step_i <= 1'h1;
      repeat (5) @(posedge clk_i);
      pc_step_i <= 1'h0;
      chk_irq(2'h0);
      chk(pc_o, 16'h0005);
      for (int i = 0; i < 2; i++) begin
         wr(`RSW_ADDR_SP, 8'h30);
         wr(`RSW_ADDR_PORT1, 8'h12);
         @(posedge clk_i);
         chk({sp_o, port1_o}, 16'h3012);
         src.pin_pulse(i ? 40 : 8);
         wait_for(1'h0, 1'h1, 20);
         chk(pc_o, 16'h0000);
         wait_for(1'h0, 1'h0, 80);
         chk(pc_o, 16'h0000);
         chk({sp_o, port1_o}, 16'h07FF);
         rdc(`RSW_ADDR_WDCTL, 8'h02);
         wr(`RSW_ADDR_RAM_ADDR, 8'h03);
         rdc(`RSW_ADDR_RAM_DATA, 8'hA5);
      end
      $display("Test external reset done");
      wr(`RSW_ADDR_INTSEL, 8'h03);
      wr(`RSW_ADDR_IRQ_MASK, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(`RSW_ADDR_WDCTL, 8'h01);
         repeat (600) @(posedge clk_i);
      end
      rdc(`RSW_ADDR_WDCTL, 8'h00);
      repeat (1100) @(posedge clk_i);
      rdc(`RSW_ADDR_WDCTL, 8'h08);
      chk_irq(2'h0);
      wr(`RSW_ADDR_XIE, 8'h10);
      chk_irq(2'h2);
      wr(`RSW_ADDR_IRQ_MASK, 8'h03);
      chk_irq(2'h3);
      wr(`RSW_ADDR_IRQ_STAT, 8'h01);
      chk_irq(2'h2);
      wr(`RSW_ADDR_IRQ_MASK, 8'h02);
      wr(`RSW_ADDR_WDCTL, 8'h00);
      chk_irq(2'h0);
      wr(`RSW_ADDR_WDCTL, 8'h08);
      chk_irq(2'h2);
      $display("Test interrupt flag done");
      wr(`RSW_ADDR_WDCTL, 8'h03);
      wait_for(1'h1, 1'h1, 1200);
      chk(16'(n > 992), 16'h0001);
      wait_for(1'h0, 1'h1, 600);
      chk(16'(n >= 16'h01FB && n <= 16'h0201), 16'h0001);
      wait_for(1'h0, 1'h0, 40);
      chk(pc_o, 16'h0000);
      rd(`RSW_ADDR_WDCTL, rv);
      chk({8'h00, rv & 8'h46}, 16'h0006);
      chk_irq(2'h1);
      rdc(`RSW_ADDR_XIE, 8'h00);
      rdc(`RSW_ADDR_INTSEL, 8'h00);
      $display("Test watchdog reset done");
      pc_step_i <= 1'h1;
      src.por_pulse(4);
      wait_for(1'h0, 1'h1, 20);
      chk(pc_o, 16'h0000);
      wait_for(1'h0, 1'h0, 80);
      pc_step_i <= 1'h0;
      rdc(`RSW_ADDR_WDCTL, 8'h40);
      $display("Test power-on reset done");
      report_and_stop();
   end
endmodule
